/* rtl/dac_toggle_monitor_thermal_ctrl.sv */
// Purpose: Control logic for a multichannel DAC: reference, monitor, toggle, thermal
// Assumes: APB master; load strobe and overtemp arrive as asynchronous pins
// Notes: Variant strap is caught on the first clock after reset release
//
// Summary of operation
// - After reset the external reference is selected until control chooses internal.
// - Wide variant: bit 12 picks level, bit 10 selects internal reference.
// - Narrow variant: bit 10 picks level, bit 8 selects internal reference.
// - Monitor code 63 leaves the monitor pin undriven.
// - Monitor can route either external monitor input or any channel.
// - Select bits zero and address 1100 make a control register write.
// - Toggle mode is enabled per group of eight channels by two bits.
// - B register writes take effect only while the group toggles.
// - In toggle mode first strobe loads A, then strobes alternate B and A.
// - First strobe after toggle disable loads the A registers.
// - Thermal monitor enable is bit 8 wide, bit 6 narrow.
// - Enabled overtemperature powers down all output amplifiers.
// - Shutdown holds until soft power-up when cool or monitor disable.
// - Each channel has its own offset and gain register.
// - Outside toggle mode a strobe updates a channel only if its corrected data was rewritten or toggle was just disabled.
// - A strobe during correction is held and applied when it finishes.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module dac_toggle_monitor_thermal_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // Pins
  input wire logic i_variant_narrow,
  input wire logic i_load_dac_strobe_n,
  input wire logic i_overtemp,
  // Analog control
  output logic o_ref_internal,
  output logic o_ref_level_high,
  output logic o_amp_powerdown,
  output logic o_mon_drive,
  output logic [5:0] o_mon_code,
  output logic [1:0] o_mon_ext_sel,
  output logic o_busy,
  output logic [dac_ctrl_pkg::NUM_CH*dac_ctrl_pkg::DW-1:0] o_dac_codes
);
  import dac_ctrl_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic pick_bit(input logic [13:0] cr, input logic narrow, input int wpos, input int npos);
    pick_bit = narrow ? cr[npos] : cr[wpos];
  endfunction

  function automatic logic [5:0] mon_fwd(input logic en, input logic [5:0] code);
    mon_fwd = en ? code : MON_HIZ;
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic narrow_r;
  logic strap_done_r;
  logic [13:0] ctrl_r;
  logic [6:0] mon_r;
  logic [13:0] gain_r [NUM_CH];
  logic [13:0] offset_r [NUM_CH];
  logic [13:0] x2a_r [NUM_CH];
  logic [13:0] x2b_r [NUM_CH];
  logic [13:0] dac_r [NUM_CH];
  logic [NUM_CH-1:0] dirty_r;
  logic [1:0] tog_prev_r;
  logic [1:0] tsel_r;
  logic [1:0] force_a_r;
  logic pend_r;
  logic ot_flag_r;
  logic [3:0] wr_ch_r;
  logic wr_b_r;
  logic [31:0] prdata_r;
  logic [2:0] ld_sync_r;
  logic [2:0] ot_sync_r;
  logic ld_lvl_r;
  logic ot_lvl_r;
  logic [5:0] mon_code_r;
  logic mon_drive_r;
  logic [1:0] mon_ext_r;

  corr_if cif ();

  corr_engine u_corr (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .c(cif.eng)
  );

  // ----------------------------------------
  // Variant strap
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      narrow_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      narrow_r <= i_variant_narrow;
      strap_done_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // A level counts only once the second and third stages agree
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ld_sync_r <= 3'h7;
      ot_sync_r <= 3'h0;
      ld_lvl_r <= 1'b1;
      ot_lvl_r <= 1'b0;
    end else begin
      ld_sync_r <= {ld_sync_r[1:0], i_load_dac_strobe_n};
      ot_sync_r <= {ot_sync_r[1:0], i_overtemp};
      if (ld_sync_r[1] == ld_sync_r[2]) begin
        ld_lvl_r <= ld_sync_r[2];
      end
      if (ot_sync_r[1] == ot_sync_r[2]) begin
        ot_lvl_r <= ot_sync_r[2];
      end
    end
  end

  logic ld_fall;
  assign ld_fall = ld_lvl_r && (ld_sync_r[1] == ld_sync_r[2]) && !ld_sync_r[2];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic mapped;
  logic cmd_stall;
  logic wr_en;
  logic cmd_wr;
  logic [1:0] cmd_sel;
  logic [5:0] cmd_addr;
  logic [3:0] cmd_ch;
  logic sfr_wr;
  logic ctrl_wr;
  logic soft_up;
  logic mon_wr;
  logic busy;

  assign busy = cif.busy;
  assign mapped = (i_paddr == ADDR_CMD) || (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS)
                  || (i_paddr == ADDR_MON);
  // Data writes wait while a correction is running, so none is lost
  assign cmd_stall = i_pwrite && (i_paddr == ADDR_CMD) && busy;
  assign o_pready = !cmd_stall;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign wr_en = i_psel && i_penable && o_pready && i_pwrite && mapped;
  assign cmd_wr = wr_en && (i_paddr == ADDR_CMD);
  assign cmd_sel = i_pwdata[CMD_SEL_POS +: 2];
  assign cmd_addr = i_pwdata[CMD_ADDR_POS +: 6];
  assign cmd_ch = cmd_addr[3:0];
  assign sfr_wr = cmd_wr && (cmd_sel == SEL_SFR);
  assign ctrl_wr = (sfr_wr && (cmd_addr[3:0] == SFR_CTRL)) || (wr_en && i_paddr == ADDR_CTRL);
  assign soft_up = sfr_wr && (cmd_addr[3:0] == SFR_SOFT_UP);
  assign mon_wr = (sfr_wr && (cmd_addr[3:0] == SFR_MON)) || (wr_en && i_paddr == ADDR_MON);

  // ----------------------------------------
  // Control register and decoded modes
  // ----------------------------------------
  logic [1:0] tog_en;
  logic therm_en;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_r <= i_pwdata[13:0];
    end
  end

  assign tog_en[1] = pick_bit(ctrl_r, narrow_r, CR_TOG_HI_W, CR_TOG_HI_N);
  assign tog_en[0] = pick_bit(ctrl_r, narrow_r, CR_TOG_LO_W, CR_TOG_LO_N);
  assign therm_en = pick_bit(ctrl_r, narrow_r, CR_THERM_W, CR_THERM_N);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ref_internal <= 1'b0;
      o_ref_level_high <= 1'b0;
    end else begin
      o_ref_internal <= pick_bit(ctrl_r, narrow_r, CR_INTREF_W, CR_INTREF_N);
      o_ref_level_high <= pick_bit(ctrl_r, narrow_r, CR_LEVEL_W, CR_LEVEL_N);
    end
  end

  // ----------------------------------------
  // Monitor multiplexer
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mon_r <= {1'b0, MON_HIZ};
    end else if (mon_wr) begin
      mon_r <= i_pwdata[MON_EN_POS:0];
    end
  end

  // Codes that name no source leave the pin undriven as well
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mon_code_r <= MON_HIZ;
      mon_drive_r <= 1'b0;
      mon_ext_r <= 2'b00;
    end else begin
      mon_code_r <= mon_fwd(mon_r[MON_EN_POS], mon_r[5:0]);
      mon_drive_r <= mon_r[MON_EN_POS] && (mon_r[5:0] != MON_HIZ) && (mon_r[5:0] <= MON_IN_TWO);
      mon_ext_r <= {mon_r[MON_EN_POS] && (mon_r[5:0] == MON_IN_TWO),
                    mon_r[MON_EN_POS] && (mon_r[5:0] == MON_IN_ONE)};
    end
  end

  assign o_mon_code = mon_code_r;
  assign o_mon_drive = mon_drive_r;
  assign o_mon_ext_sel = mon_ext_r;

  // ----------------------------------------
  // Gain and offset per channel
  // ----------------------------------------
  logic cal_ok;
  assign cal_ok = cmd_wr && (cmd_addr[5:4] == 2'b00);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        gain_r[i] <= GAIN_RESET;
        offset_r[i] <= OFFSET_RESET;
      end
    end else if (cal_ok) begin
      if (cmd_sel == SEL_GAIN) begin
        gain_r[cmd_ch] <= i_pwdata[13:0];
      end else if (cmd_sel == SEL_OFFSET) begin
        offset_r[cmd_ch] <= i_pwdata[13:0];
      end
    end
  end

  // ----------------------------------------
  // Data writes through the correction engine
  // ----------------------------------------
  logic data_wr;
  // A B write to a group that is not toggling is dropped
  assign data_wr = cal_ok && (cmd_sel == SEL_DATA) && (!i_pwdata[CMD_AB_POS] || tog_en[cmd_ch[3]]);
  assign cif.start = data_wr;
  assign cif.x1 = i_pwdata[13:0];
  assign cif.gain = gain_r[cmd_ch];
  assign cif.offset = offset_r[cmd_ch];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ch_r <= 4'h0;
      wr_b_r <= 1'b0;
    end else if (data_wr) begin
      wr_ch_r <= cmd_ch;
      wr_b_r <= i_pwdata[CMD_AB_POS];
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        x2a_r[i] <= CODE_RESET;
        x2b_r[i] <= CODE_RESET;
      end
    end else if (cif.done) begin
      if (wr_b_r) begin
        x2b_r[wr_ch_r] <= cif.result;
      end else begin
        x2a_r[wr_ch_r] <= cif.result;
      end
    end
  end

  // ----------------------------------------
  // Load strobe and toggle
  // ----------------------------------------
  logic apply;
  logic [1:0] tog_chg;
  assign apply = pend_r && !busy;
  assign tog_chg = tog_en ^ tog_prev_r;

  // A strobe held low through a correction fires again when it ends
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= ld_fall || (!ld_lvl_r && cif.done) || (pend_r && !apply);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dirty_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (cif.done && !wr_b_r && wr_ch_r == 4'(i)) begin
          dirty_r[i] <= 1'b1;
        end else if (apply) begin
          dirty_r[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tog_prev_r <= 2'b00;
      tsel_r <= 2'b00;
      force_a_r <= 2'b00;
    end else begin
      tog_prev_r <= tog_en;
      for (int g = 0; g < 2; g++) begin
        if (tog_chg[g]) begin
          tsel_r[g] <= 1'b0;
        end else if (apply && tog_en[g]) begin
          tsel_r[g] <= !tsel_r[g];
        end
        if (tog_chg[g] && !tog_en[g]) begin
          force_a_r[g] <= 1'b1;
        end else if (apply) begin
          force_a_r[g] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        dac_r[i] <= CODE_RESET;
      end
    end else if (apply) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (tog_en[i / 8]) begin
          dac_r[i] <= tsel_r[i / 8] ? x2b_r[i] : x2a_r[i];
        end else if (force_a_r[i / 8] || dirty_r[i]) begin
          dac_r[i] <= x2a_r[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      o_dac_codes[i*DW +: DW] = dac_r[i];
    end
  end

  // ----------------------------------------
  // Thermal shutdown
  // ----------------------------------------
  // A soft power-up while still hot is overridden by the trip
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ot_flag_r <= 1'b0;
    end else begin
      ot_flag_r <= (therm_en && ot_lvl_r) || (ot_flag_r && therm_en && !soft_up);
    end
  end

  assign o_amp_powerdown = ot_flag_r;
  assign o_busy = busy;

  // ----------------------------------------
  // Read data, captured in the setup phase
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prdata_r <= 32'h0;
    end else if (i_psel && !i_penable) begin
      unique case (i_paddr)
        ADDR_CTRL: prdata_r <= {18'h0, ctrl_r};
        ADDR_STATUS: prdata_r <= {24'h0, force_a_r, tsel_r, narrow_r, ot_flag_r, pend_r, busy};
        ADDR_MON: prdata_r <= {25'h0, mon_r};
        default: prdata_r <= 32'h0;
      endcase
    end
  end

  assign o_prdata = prdata_r;
endmodule

/* rtl/dac_ctrl_pkg.sv */
// Purpose: Shared constants for the DAC control block
// Assumes: 16 channels of 14-bit codes, APB word registers
// Notes: Offsets are byte addresses
package dac_ctrl_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_CH = 16;
  localparam int DW = 14;
  localparam int CORR_CYCLES = 4;
  // ----------------------------------------
  // APB register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MON = 8'h0c;
  // ----------------------------------------
  // Command word layout
  // ----------------------------------------
  localparam int CMD_SEL_POS = 22;
  localparam int CMD_ADDR_POS = 16;
  localparam int CMD_AB_POS = 15;
  localparam logic [1:0] SEL_SFR = 2'h0;
  localparam logic [1:0] SEL_GAIN = 2'h1;
  localparam logic [1:0] SEL_OFFSET = 2'h2;
  localparam logic [1:0] SEL_DATA = 2'h3;
  localparam logic [3:0] SFR_CTRL = 4'hc;
  localparam logic [3:0] SFR_SOFT_UP = 4'h9;
  localparam logic [3:0] SFR_MON = 4'ha;
  localparam int MON_EN_POS = 6;
  // ----------------------------------------
  // Control bit positions
  // ----------------------------------------
  localparam int CR_LEVEL_W = 12;
  localparam int CR_LEVEL_N = 10;
  localparam int CR_INTREF_W = 10;
  localparam int CR_INTREF_N = 8;
  localparam int CR_THERM_W = 8;
  localparam int CR_THERM_N = 6;
  localparam int CR_TOG_HI_W = 3;
  localparam int CR_TOG_LO_W = 2;
  localparam int CR_TOG_HI_N = 1;
  localparam int CR_TOG_LO_N = 0;
  // ----------------------------------------
  // Monitor codes and reset values
  // ----------------------------------------
  localparam logic [5:0] MON_IN_ONE = 6'h10;
  localparam logic [5:0] MON_IN_TWO = 6'h11;
  localparam logic [5:0] MON_HIZ = 6'h3f;
  localparam logic [13:0] CTRL_RESET = 14'h0000;
  localparam logic [13:0] GAIN_RESET = 14'h3fff;
  localparam logic [13:0] OFFSET_RESET = 14'h2000;
  localparam logic [13:0] CODE_RESET = 14'h0000;
endpackage

/* rtl/corr_if.sv */
// Purpose: Carrier between the control logic and the correction engine
// Assumes: One request at a time
// Notes: start is a one-cycle pulse, done likewise
`timescale 1ns/10ps
interface corr_if;
  logic start;
  logic [13:0] x1;
  logic [13:0] gain;
  logic [13:0] offset;
  logic busy;
  logic done;
  logic [13:0] result;
  modport ctl(output start, x1, gain, offset, input busy, done, result);
  modport eng(input start, x1, gain, offset, output busy, done, result);
endinterface

/* rtl/corr_engine.sv */
// Purpose: Applies per-channel gain and offset to a data word
// Assumes: Requests arrive only while busy is low
// Notes: Result saturates to the code range
`timescale 1ns/10ps
module corr_engine (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Request and answer
  corr_if.eng c
);
  import dac_ctrl_pkg::*;
  typedef enum logic [0:0] {ST_IDLE, ST_CALC} eng_state_type;
  eng_state_type state_r;
  logic [2:0] cnt_r;
  logic [28:0] prod_r;
  logic [13:0] off_r;
  logic [15:0] sum;
  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      prod_r <= 29'h0;
      off_r <= 14'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (c.start) begin
            state_r <= ST_CALC;
            cnt_r <= 3'(CORR_CYCLES - 1);
            prod_r <= 29'(c.x1) * (29'(c.gain) + 29'h1);
            off_r <= c.offset;
          end
        end
        ST_CALC: begin
          cnt_r <= cnt_r - 3'h1;
          if (cnt_r == 3'h0) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end
  // Gain scales by (g+1)/2^14, offset is centred on mid-scale
  assign sum = 16'(prod_r[28:14]) + {2'b00, off_r} - {2'b00, OFFSET_RESET};
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c.result <= CODE_RESET;
    end else if (state_r == ST_CALC && cnt_r == 3'h0) begin
      c.result <= sum[15] ? 14'h0 : sum[14] ? 14'h3fff : sum[13:0];
    end
  end
  assign c.busy = (state_r == ST_CALC) || c.done;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c.done <= 1'b0;
    end else begin
      c.done <= (state_r == ST_CALC) && (cnt_r == 3'h0);
    end
  end
endmodule

/* verification/dac_ctrl_asserts.sv */
// Purpose: Port-level checks for the DAC control block
// Assumes: One clock, asynchronous active-low reset
// Notes: Attached to the top module by bind
`timescale 1ns/10ps
module dac_ctrl_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Inputs of the block
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic i_variant_narrow,
  input wire logic i_load_dac_strobe_n,
  input wire logic i_overtemp,
  // Outputs of the block
  input wire logic o_pready,
  input wire logic o_ref_internal,
  input wire logic o_ref_level_high,
  input wire logic o_amp_powerdown,
  input wire logic o_mon_drive,
  input wire logic [5:0] o_mon_code,
  input wire logic [1:0] o_mon_ext_sel,
  input wire logic [dac_ctrl_pkg::NUM_CH*dac_ctrl_pkg::DW-1:0] o_dac_codes
);
  import dac_ctrl_pkg::*;
  logic wr;
  logic [4:0] since_ld_r;
  assign wr = i_psel & i_penable & o_pready & i_pwrite;
  // Saturates so a long quiet spell never wraps back into the legal window
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      since_ld_r <= 5'h1f;
    end else if (!i_load_dac_strobe_n) begin
      since_ld_r <= 5'h00;
    end else if (since_ld_r != 5'h1f) begin
      since_ld_r <= since_ld_r + 5'h01;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  AST_REF_EXT: assert property ($rose(o_ref_internal) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("internal reference chosen without a register write");
  AST_WIDE_MAP: assert property (wr && i_paddr == ADDR_CTRL && !i_variant_narrow |-> ##2
    o_ref_internal == $past(i_pwdata[CR_INTREF_W], 2) && o_ref_level_high == $past(i_pwdata[CR_LEVEL_W], 2))
    else $error("wide control bits not mapped to reference outputs");
  AST_NARROW_MAP: assert property (wr && i_paddr == ADDR_CTRL && i_variant_narrow |-> ##2
    o_ref_internal == $past(i_pwdata[CR_INTREF_N], 2) && o_ref_level_high == $past(i_pwdata[CR_LEVEL_N], 2))
    else $error("narrow control bits not mapped to reference outputs");
  AST_MON_HIZ: assert property (o_mon_code == MON_HIZ |-> !o_mon_drive && o_mon_ext_sel == 2'b00)
    else $error("monitor pin driven with code 63");
  AST_MON_EXT: assert property (o_mon_drive |-> o_mon_ext_sel == {o_mon_code == MON_IN_TWO,
    o_mon_code == MON_IN_ONE})
    else $error("external monitor select does not match code");
  AST_THERM_SET: assert property ($rose(o_amp_powerdown) |-> $past(i_overtemp, 2))
    else $error("amplifiers powered down without overtemperature");
  AST_THERM_HOLD: assert property ($fell(o_amp_powerdown) |-> $past(wr) || $past(wr, 2))
    else $error("shutdown released without a register write");
  AST_LOAD_CAUSE: assert property (!$stable(o_dac_codes) |-> since_ld_r < 5'd14)
    else $error("dac codes changed without a load strobe");
endmodule
bind dac_toggle_monitor_thermal_ctrl dac_ctrl_asserts i_dac_ctrl_asserts (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .i_variant_narrow(i_variant_narrow), .i_load_dac_strobe_n(i_load_dac_strobe_n), .i_overtemp(i_overtemp),
  .o_pready(o_pready), .o_ref_internal(o_ref_internal), .o_ref_level_high(o_ref_level_high),
  .o_amp_powerdown(o_amp_powerdown), .o_mon_drive(o_mon_drive), .o_mon_code(o_mon_code),
  .o_mon_ext_sel(o_mon_ext_sel), .o_dac_codes(o_dac_codes));

/* verification/host_strobe_model.sv */
// Purpose: Host-side model that pulses the load strobe pin
// Assumes: Host may fire before its last register load has finished correction
// Notes: Pulse width per request, so quick and lingering hosts can be mimicked
`timescale 1ns/10ps
module host_strobe_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Request from the bench
  input wire logic i_fire,
  input wire logic [7:0] i_low_cycles,
  // Pin toward the device
  output logic o_load_dac_strobe_n
);
  logic [7:0] cnt_r;
  // Fired on bench request, also while a data write is still in correction
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= 8'h00;
    end else if (i_fire) begin
      cnt_r <= i_low_cycles;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign o_load_dac_strobe_n = (cnt_r == 8'h00);
endmodule

/* verification/tb.sv */
// Purpose: Self-checking bench for the DAC control block
// Assumes: Reset gain and offset leave corrected data equal to raw data
// Notes: Read results are checked by a monitor off a queue of notes
`timescale 1ns/10ps
module tb;
  import dac_ctrl_pkg::*;
  logic i_clk, i_resetn, i_psel, i_penable, i_pwrite, i_variant_narrow, i_overtemp, fire, ld_n;
  logic o_pready, o_pslverr, o_ref_internal, o_ref_level_high, o_amp_powerdown, o_mon_drive, o_busy;
  logic [7:0] i_paddr, low_cycles;
  logic [31:0] i_pwdata, o_prdata, seed;
  logic [5:0] o_mon_code;
  logic [1:0] o_mon_ext_sel;
  logic [NUM_CH*DW-1:0] o_dac_codes;
  logic [13:0] a, b;
  logic [5:0] mc [5];
  logic [31:0] rd_q [$];
  int num_errors, samples_checked;
  dac_toggle_monitor_thermal_ctrl i_dac_toggle_monitor_thermal_ctrl (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata), .i_variant_narrow(i_variant_narrow),
    .i_load_dac_strobe_n(ld_n), .i_overtemp(i_overtemp), .o_ref_internal(o_ref_internal),
    .o_ref_level_high(o_ref_level_high), .o_amp_powerdown(o_amp_powerdown), .o_mon_drive(o_mon_drive),
    .o_mon_code(o_mon_code), .o_mon_ext_sel(o_mon_ext_sel), .o_busy(o_busy), .o_dac_codes(o_dac_codes));
  host_strobe_model i_host_strobe_model (.i_clk(i_clk), .i_resetn(i_resetn), .i_fire(fire),
    .i_low_cycles(low_cycles), .o_load_dac_strobe_n(ld_n));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [13:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[13:0];
  endfunction
  function automatic logic [31:0] code(input int ch);
    return 32'(o_dac_codes[ch*DW +: DW]);
  endfunction
  // For reads, d is the expected read data
  task automatic apb(input logic [7:0] ad, input logic w, input logic [31:0] d);
    logic ok;
    int n;
    ok = 1'b0;
    n = 0;
    if (!w) rd_q.push_back(d);
    i_psel <= 1'b1;
    i_paddr <= ad;
    i_pwrite <= w;
    i_pwdata <= w ? d : 32'h0;
    @(posedge i_clk);
    i_penable <= 1'b1;
    while (!ok && n < 40) begin
      @(posedge i_clk);
      ok = (o_pready === 1'b1);
      n++;
    end
    if (!ok) begin
      num_errors++;
      stop_test();
    end
    check(32'(o_pslverr), 32'(ad > ADDR_MON || ad[1:0] != 2'h0));
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic cmd(input logic [1:0] s, input logic [5:0] ad, input logic bsel, input logic [13:0] d);
    apb(ADDR_CMD, 1'b1, {8'h00, s, ad, bsel, 1'b0, d});
  endtask
  task automatic ld(input logic [7:0] w);
    low_cycles <= w;
    fire <= 1'b1;
    @(posedge i_clk);
    fire <= 1'b0;
    repeat (24) @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite) begin
      check(o_prdata, rd_q.pop_front());
    end
  end
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    stop_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {i_resetn, i_psel, i_penable, i_pwrite, i_variant_narrow, i_overtemp, fire} = 7'h00;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    low_cycles = 8'h06;
    seed = 32'ha22bfbbb;
    mc = '{6'h00, 6'h0f, MON_IN_ONE, MON_IN_TWO, MON_HIZ};
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_clk);
    check(32'(o_ref_internal), 32'h0);
    check(32'(o_mon_drive), 32'h0);
    apb(8'h10, 1'b0, 32'h0);
    cmd(SEL_GAIN, {2'b00, SFR_CTRL}, 1'b0, 14'h0400);
    repeat (3) @(posedge i_clk);
    check(32'(o_ref_internal), 32'h0);
    cmd(SEL_SFR, {2'b00, SFR_CTRL}, 1'b0, 14'h1400);
    repeat (3) @(posedge i_clk);
    check(32'({o_ref_internal, o_ref_level_high}), 32'h3);
    for (int i = 0; i < 5; i++) begin
      // Enable travels in the same write as the code
      cmd(SEL_SFR, {2'b00, SFR_MON}, 1'b0, 14'(7'h40 | 7'(mc[i])));
      repeat (3) @(posedge i_clk);
      check(32'(o_mon_code), 32'(mc[i]));
      check(32'(o_mon_drive), 32'(mc[i] <= 6'h11));
      check(32'(o_mon_ext_sel), 32'({mc[i] == MON_IN_TWO, mc[i] == MON_IN_ONE}));
    end
    a = rnd();
    b = rnd();
    apb(ADDR_CTRL, 1'b1, 32'h4);
    cmd(SEL_DATA, 6'h00, 1'b0, a);
    cmd(SEL_DATA, 6'h00, 1'b1, b);
    cmd(SEL_DATA, 6'h08, 1'b1, b);
    for (int i = 0; i < 4; i++) begin
      ld(8'h06);
      check(code(0), 32'(i[0] ? b : a));
    end
    check(code(8), 32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h0);
    cmd(SEL_OFFSET, 6'h0c, 1'b0, 14'h2010);
    cmd(SEL_DATA, 6'h0c, 1'b0, 14'h1000);
    ld(8'h06);
    check(code(0), 32'(a));
    check(code(12), 32'h110);
    a = rnd();
    low_cycles <= 8'h03;
    fire <= 1'b1;
    cmd(SEL_DATA, 6'h01, 1'b0, a);
    fire <= 1'b0;
    check(32'(o_busy), 32'h1);
    repeat (24) @(posedge i_clk);
    check(code(1), 32'(a));
    i_overtemp <= 1'b1;
    repeat (8) @(posedge i_clk);
    check(32'(o_amp_powerdown), 32'h0);
    apb(ADDR_CTRL, 1'b1, 32'h100);
    apb(ADDR_CTRL, 1'b0, 32'h100);
    repeat (8) @(posedge i_clk);
    check(32'(o_amp_powerdown), 32'h1);
    cmd(SEL_SFR, {2'b00, SFR_SOFT_UP}, 1'b0, 14'h0);
    i_overtemp <= 1'b0;
    repeat (8) @(posedge i_clk);
    check(32'(o_amp_powerdown), 32'h1);
    cmd(SEL_SFR, {2'b00, SFR_SOFT_UP}, 1'b0, 14'h0);
    repeat (3) @(posedge i_clk);
    check(32'(o_amp_powerdown), 32'h0);
    i_overtemp <= 1'b1;
    repeat (8) @(posedge i_clk);
    apb(ADDR_CTRL, 1'b1, 32'h0);
    repeat (3) @(posedge i_clk);
    check(32'(o_amp_powerdown), 32'h0);
    i_overtemp <= 1'b0;
    i_resetn <= 1'b0;
    i_variant_narrow <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_clk);
    apb(ADDR_CTRL, 1'b1, 32'h540);
    repeat (3) @(posedge i_clk);
    check(32'({o_ref_internal, o_ref_level_high}), 32'h3);
    i_overtemp <= 1'b1;
    repeat (8) @(posedge i_clk);
    check(32'(o_amp_powerdown), 32'h1);
    stop_test();
  end
endmodule
